// [core/event_sticky.sv]
`default_nettype none
`include "spi_status_params.svh"
module event_sticky
  import spi_status_pkg::*;
(
  input  wire logic                 clk,        // clock
  input  wire logic                 rst_n,      // async reset
  input  wire logic                 ce,         // clock enable
  input  wire logic [`EVENT_W-1:0]  events,     // event pulses
  input  wire logic                 stat_wr,    // write to status
  input  wire logic                 mask_wr,    // write to mask
  input  wire logic [`EVENT_W-1:0]  wdata,      // write data
  output logic      [`EVENT_W-1:0]  status,     // sticky bits
  output logic      [`EVENT_W-1:0]  mask,       // enable bits
  output logic                      irq         // level interrupt
);
  logic [`EVENT_W-1:0] status_q;
  logic [`EVENT_W-1:0] mask_q;
  logic                irq_q;

  genvar i;
  generate
    for (i = 0; i < `EVENT_W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          status_q[i] <= 1'b0;
        end else if (ce) begin
          if (events[i]) begin
            status_q[i] <= 1'b1;
          end else if (stat_wr && wdata[i]) begin
            status_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `EVENT_ZERO;
    end else if (ce && mask_wr) begin
      mask_q <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign status = status_q;
  assign mask   = mask_q;
  assign irq    = irq_q;
endmodule
`default_nettype wire

// [core/occupancy_tracker.sv]
`default_nettype none
`include "spi_status_params.svh"
module occupancy_tracker
  import spi_status_pkg::*;
(
  input  wire logic        clk,      // clock
  input  wire logic        rst_n,    // async reset
  occupancy_if.tracker     occ       // buffer events and state
);
  count_t wr_ptr_q;
  count_t rd_ptr_q;
  count_t depth;
  logic   do_push;
  logic   do_pop;

  assign depth   = occ.deep ? `DEPTH_DEEP : `DEPTH_SINGLE;
  assign do_push = occ.push && !occ.full;
  assign do_pop  = occ.pop && !occ.empty;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= `COUNT_ZERO;
    end else if (occ.ce) begin
      if (occ.flush) begin
        wr_ptr_q <= `COUNT_ZERO;
      end else if (do_push) begin
        wr_ptr_q <= wr_ptr_q + `COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= `COUNT_ZERO;
    end else if (occ.ce) begin
      if (occ.flush) begin
        rd_ptr_q <= `COUNT_ZERO;
      end else if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + `COUNT_ONE;
      end
    end
  end

  assign occ.count     = wr_ptr_q - rd_ptr_q;
  assign occ.ptr_equal = (rd_ptr_q == wr_ptr_q);
  assign occ.empty     = occ.ptr_equal;
  assign occ.full      = (occ.count >= depth);
endmodule
`default_nettype wire

// [core/spi_status_flags.sv]
// Register access over APB and the register offsets were chosen for this implementation.
`default_nettype none
`include "spi_status_params.svh"
module spi_status_flags
  import spi_status_pkg::*;
(
  input  wire logic        CLOCK,         // 40 MHz clock
  input  wire logic        RESETN,        // async reset, low
  input  wire logic        CE,            // clock enable
  input  wire logic        PSEL,          // apb select
  input  wire logic        PENABLE,       // apb access phase
  input  wire logic        PWRITE,        // apb direction
  input  wire logic [7:0]  PADDR,         // apb byte address
  input  wire logic [31:0] PWDATA,        // apb write data
  output logic      [31:0] PRDATA,        // apb read data
  output logic             PREADY,        // apb ready
  output logic             PSLVERR,       // apb error
  input  wire logic        ENABLE,        // module on
  input  wire logic        DEEP_BUF,      // deep_buffer_enable
  input  wire logic        FRAMED,        // framed_mode_enable
  input  wire logic        BUSY,          // engine busy
  input  wire logic        SHIFT_EMPTY,   // shifter holds no data
  input  wire logic        RX_WORD_DONE,  // word fully received
  input  wire logic        RX_READ,       // data buffer read
  input  wire logic        TX_WRITE,      // data buffer written
  input  wire logic        TX_LOAD,       // shifter took a word
  input  wire logic        FRAME_ERR,     // frame error seen
  input  wire logic        TX_UNDERRUN,   // transmit underrun seen
  output logic             RX_ACCEPT,     // received word stored
  output logic             RX_DISCARD,    // received word dropped
  output logic             IRQ            // interrupt level
);
  apb_phase_t phase_q;
  apb_phase_t phase_d;
  word_t      prdata_q;
  logic       pready_q;
  logic       pslverr_q;
  logic       rx_accept_q;
  logic       rx_discard_q;

  logic       enable_q;
  logic       reenable;
  logic       frame_err_q;
  logic       underrun_q;
  logic       overflow_q;
  logic       activity_q;
  logic       shift_empty_q;

  logic       setup;
  logic       access_done;
  logic       wr_en;
  logic       hit_stat;
  logic       hit_evst;
  logic       hit_mask;
  logic       mapped;
  word_t      status_word;
  word_t      read_word;

  logic       rx_overflow_evt;
  logic       rx_store_evt;
  logic       frame_err_evt;
  logic       underrun_evt;

  logic [`EVENT_W-1:0] ev_pulses;
  logic [`EVENT_W-1:0] ev_status;
  logic [`EVENT_W-1:0] ev_mask;
  logic                irq_w;

  occupancy_if rx_occ ();
  occupancy_if tx_occ ();

  // apb decode
  assign setup       = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE && pready_q;
  assign wr_en       = access_done && PWRITE && mapped;
  assign hit_stat    = (PADDR == `OFS_SERIAL_STATUS);
  assign hit_evst    = (PADDR == `OFS_EVENT_STATUS);
  assign hit_mask    = (PADDR == `OFS_EVENT_MASK);
  assign mapped      = hit_stat || hit_evst || hit_mask;

  // receive and transmit occupancy
  assign rx_occ.ce    = CE;
  assign rx_occ.deep  = DEEP_BUF;
  assign rx_occ.flush = !ENABLE;
  assign rx_occ.push  = RX_WORD_DONE && ENABLE;
  assign rx_occ.pop   = RX_READ && ENABLE;
  assign tx_occ.ce    = CE;
  assign tx_occ.deep  = DEEP_BUF;
  assign tx_occ.flush = !ENABLE;
  assign tx_occ.push  = TX_WRITE && ENABLE;
  assign tx_occ.pop   = TX_LOAD && ENABLE;

  occupancy_tracker u_rx_track (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .occ   (rx_occ)
  );

  occupancy_tracker u_tx_track (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .occ   (tx_occ)
  );

  // flag events
  assign rx_overflow_evt = RX_WORD_DONE && ENABLE && rx_occ.full;
  assign rx_store_evt    = RX_WORD_DONE && ENABLE && !rx_occ.full;
  assign frame_err_evt   = FRAME_ERR && ENABLE && FRAMED;
  assign underrun_evt    = TX_UNDERRUN && ENABLE && FRAMED;
  assign reenable        = ENABLE && !enable_q;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      enable_q <= 1'b0;
    end else if (CE) begin
      enable_q <= ENABLE;
    end
  end

  // set wins over software clear
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      frame_err_q <= 1'b0;
    end else if (CE) begin
      if (frame_err_evt) begin
        frame_err_q <= 1'b1;
      end else if (wr_en && hit_stat && !PWDATA[`BIT_FRAME_ERR]) begin
        frame_err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      underrun_q <= 1'b0;
    end else if (CE) begin
      if (underrun_evt) begin
        underrun_q <= 1'b1;
      end else if (reenable) begin
        underrun_q <= 1'b0;
      end else if (wr_en && hit_stat && !PWDATA[`BIT_TX_UNDERRUN]) begin
        underrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      overflow_q <= 1'b0;
    end else if (CE) begin
      if (rx_overflow_evt) begin
        overflow_q <= 1'b1;
      end else if (reenable) begin
        overflow_q <= 1'b0;
      end else if (wr_en && hit_stat && !PWDATA[`BIT_RX_OVERFLOW]) begin
        overflow_q <= 1'b0;
      end
    end
  end

  // engine levels sampled once
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      activity_q <= 1'b0;
    end else if (CE) begin
      activity_q <= BUSY && ENABLE;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      shift_empty_q <= 1'b1;
    end else if (CE) begin
      shift_empty_q <= SHIFT_EMPTY;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rx_accept_q  <= 1'b0;
      rx_discard_q <= 1'b0;
    end else if (CE) begin
      rx_accept_q  <= rx_store_evt;
      rx_discard_q <= rx_overflow_evt;
    end
  end

  // status word, unlisted bits stay zero
  always_comb begin
    status_word = `WORD_ZERO;
    status_word[`RX_COUNT_HI:`RX_COUNT_LO] = rx_occ.count;
    status_word[`TX_COUNT_HI:`TX_COUNT_LO] = tx_occ.count;
    status_word[`BIT_FRAME_ERR]   = frame_err_q;
    status_word[`BIT_ACTIVITY]    = activity_q;
    status_word[`BIT_TX_UNDERRUN] = underrun_q;
    status_word[`BIT_SHIFT_EMPTY] = shift_empty_q;
    status_word[`BIT_RX_OVERFLOW] = overflow_q;
    status_word[`BIT_RX_EMPTY]    = rx_occ.ptr_equal;
    status_word[`BIT_TX_EMPTY]    = tx_occ.empty;
    status_word[`BIT_TX_FULL]     = tx_occ.full;
    status_word[`BIT_RX_FULL]     = rx_occ.full;
  end

  always_comb begin
    read_word = `WORD_ZERO;
    if (hit_stat) begin
      read_word = status_word;
    end else if (hit_evst) begin
      read_word[`EVENT_W-1:0] = ev_status;
    end else if (hit_mask) begin
      read_word[`EVENT_W-1:0] = ev_mask;
    end
  end

  // event collection
  always_comb begin
    ev_pulses = `EVENT_ZERO;
    ev_pulses[`EV_FRAME_ERR]   = frame_err_evt;
    ev_pulses[`EV_TX_UNDERRUN] = underrun_evt;
    ev_pulses[`EV_RX_OVERFLOW] = rx_overflow_evt;
    ev_pulses[`EV_RX_WORD]     = rx_store_evt;
  end

  event_sticky u_events (
    .clk     (CLOCK),
    .rst_n   (RESETN),
    .ce      (CE),
    .events  (ev_pulses),
    .stat_wr (wr_en && hit_evst),
    .mask_wr (wr_en && hit_mask),
    .wdata   (PWDATA[`EVENT_W-1:0]),
    .status  (ev_status),
    .mask    (ev_mask),
    .irq     (irq_w)
  );

  // apb slave: one access cycle, no waits
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PH_IDLE: begin
        if (setup) begin
          phase_d = PH_ACCESS;
        end
      end
      PH_ACCESS: begin
        if (setup) begin
          phase_d = PH_ACCESS;
        end else begin
          phase_d = PH_IDLE;
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      phase_q <= PH_IDLE;
    end else if (CE) begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pready_q <= 1'b0;
    end else if (CE) begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pslverr_q <= 1'b0;
    end else if (CE) begin
      pslverr_q <= setup && !mapped;
    end
  end

  // read data captured during setup
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_q <= `WORD_ZERO;
    end else if (CE) begin
      if (setup && !PWRITE) begin
        prdata_q <= read_word;
      end else if (access_done) begin
        prdata_q <= `WORD_ZERO;
      end
    end
  end

  assign PRDATA     = prdata_q;
  assign PREADY     = pready_q;
  assign PSLVERR    = pslverr_q;
  assign RX_ACCEPT  = rx_accept_q;
  assign RX_DISCARD = rx_discard_q;
  assign IRQ        = irq_w;
endmodule
`default_nettype wire

// [include/occupancy_if.sv]
`default_nettype none
interface occupancy_if;
  logic       push;
  logic       pop;
  logic       deep;
  logic       flush;
  logic       ce;
  logic [4:0] count;
  logic       empty;
  logic       full;
  logic       ptr_equal;
  modport tracker (input push, pop, deep, flush, ce, output count, empty, full, ptr_equal);
  modport user (output push, pop, deep, flush, ce, input count, empty, full, ptr_equal);
endinterface
`default_nettype wire

// [include/spi_status_params.svh]
`ifndef SPI_STATUS_PARAMS_SVH
`define SPI_STATUS_PARAMS_SVH

`define OFS_SERIAL_STATUS 8'h00
`define OFS_EVENT_STATUS  8'h04
`define OFS_EVENT_MASK    8'h08

`define RX_COUNT_HI       28
`define RX_COUNT_LO       24
`define TX_COUNT_HI       20
`define TX_COUNT_LO       16
`define BIT_FRAME_ERR     12
`define BIT_ACTIVITY      11
`define BIT_TX_UNDERRUN   8
`define BIT_SHIFT_EMPTY   7
`define BIT_RX_OVERFLOW   6
`define BIT_RX_EMPTY      5
`define BIT_TX_EMPTY      3
`define BIT_TX_FULL       1
`define BIT_RX_FULL       0

`define DEPTH_DEEP        5'h10
`define DEPTH_SINGLE      5'h01
`define COUNT_ZERO        5'h00
`define COUNT_ONE         5'h01

`define EV_FRAME_ERR      0
`define EV_TX_UNDERRUN    1
`define EV_RX_OVERFLOW    2
`define EV_RX_WORD        3
`define EVENT_W           4
`define EVENT_ZERO        4'h0
`define WORD_ZERO         32'h0000_0000

`endif

// [include/spi_status_pkg.sv]
`default_nettype none
package spi_status_pkg;
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_ACCESS = 2'b01
  } apb_phase_t;
  typedef logic [4:0] count_t;
  typedef logic [31:0] word_t;
endpackage
`default_nettype wire

// [sim/engine_model.sv]
`default_nettype none
module engine_model (
  input  wire logic       clk,      // clock
  input  wire logic       rst_n,    // async reset, low
  input  wire logic       run,      // traffic on
  input  wire logic       drain,    // only pops
  input  wire logic [5:0] rnd,      // random bits
  output logic            rx_done,  // word received
  output logic            rx_read,  // data buffer read
  output logic            tx_write, // data buffer written
  output logic            tx_load   // shifter took a word
);
  timeunit 1ns;
  timeprecision 1ps;
  // push and pop of one buffer never share a cycle; filling outruns reading
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n || !run) begin
      rx_done  <= 1'b0;
      rx_read  <= 1'b0;
      tx_write <= 1'b0;
      tx_load  <= 1'b0;
    end else begin
      rx_done  <= !drain && rnd[0];
      rx_read  <= rnd[1] && (drain || (rnd[2] && !rnd[0]));
      tx_write <= !drain && rnd[3];
      tx_load  <= rnd[4] && (drain || (rnd[5] && !rnd[3]));
    end
  end
endmodule
`default_nettype wire

// [sim/spi_status_flags_asserts.sv]
`default_nettype none
module spi_status_flags_asserts (
  input wire logic        CLOCK,        // clock
  input wire logic        RESETN,       // async reset, low
  input wire logic        CE,           // clock enable
  input wire logic        PSEL,         // apb select
  input wire logic        PENABLE,      // apb access
  input wire logic        PWRITE,       // apb direction
  input wire logic [7:0]  PADDR,        // apb address
  input wire logic [31:0] PRDATA,       // apb read data
  input wire logic        PREADY,       // apb ready
  input wire logic        PSLVERR,      // apb error
  input wire logic        ENABLE,       // module on
  input wire logic        RX_WORD_DONE, // word received
  input wire logic        RX_ACCEPT,    // word stored
  input wire logic        RX_DISCARD    // word dropped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_setup;
    PSEL && !PENABLE && CE;
  endsequence
  sequence s_access;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence s_read_stat;
    s_access ##0 (!PWRITE && PADDR == 8'h00);
  endsequence
  a_ready_setup: assert property (s_setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_single: assert property (s_access |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_idle: assert property (!PSEL |=> !PREADY)
    else $error("ready without select");
  a_err_unmapped: assert property (PREADY |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08}))
    else $error("error flag wrong for address");
  a_data_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
    else $error("read data outside access");
  a_unimpl_zero: assert property (s_read_stat |-> (PRDATA & 32'hE0E0_E614) == 32'h0)
    else $error("unimplemented status bit set");
  a_word_outcome: assert property (RX_WORD_DONE && ENABLE && CE |=> RX_ACCEPT != RX_DISCARD)
    else $error("received word neither stored nor dropped");
  a_event_off: assert property (!ENABLE |=> !RX_ACCEPT && !RX_DISCARD)
    else $error("word taken while disabled");
  a_accept_cause: assert property (RX_ACCEPT |-> $past(RX_WORD_DONE))
    else $error("word stored without arrival");
endmodule
bind spi_status_flags spi_status_flags_asserts u_chk (.CLOCK, .RESETN, .CE, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .ENABLE, .RX_WORD_DONE, .RX_ACCEPT, .RX_DISCARD);
`default_nettype wire

// [sim/spi_status_flags_tb.sv]
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module spi_status_flags_tb import spi_status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLOCK = 0, RESETN = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic        ENABLE = 0, DEEP_BUF = 0, FRAMED = 0, BUSY = 0, SHIFT_EMPTY = 1;
  logic        FRAME_ERR = 0, TX_UNDERRUN = 0, run = 0, drain = 0;
  logic        PREADY, PSLVERR, RX_ACCEPT, RX_DISCARD, IRQ;
  logic        RX_WORD_DONE, RX_READ, TX_WRITE, TX_LOAD;
  logic [7:0]  PADDR = 8'h00;
  word_t       PWDATA = 32'h0, PRDATA, r;
  logic [31:0] lf = 32'h9BFB;
  logic [5:0]  rnd = 6'h00;
  count_t      rxc = 0, txc = 0;
  logic [3:0]  ev = 0;
  logic        fe = 0, tur = 0, ov = 0, aq = 0, dq = 0, er = 0;
  int          n_fail = 0, checked = 0;
  always #12.5 CLOCK = ~CLOCK;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // buffer depth: sixteen words when deep, else one
  function automatic count_t full_at();
    return DEEP_BUF ? 5'h10 : 5'h01;
  endfunction
  function automatic word_t exp_stat();
    return {3'h0, rxc, 3'h0, txc, 3'h0, fe, BUSY & ENABLE, 2'h0, tur, SHIFT_EMPTY, ov,
            rxc == 5'h00, 1'b0, txc == 5'h00, 1'b0, txc >= full_at(), rxc >= full_at()};
  endfunction
  always @(posedge CLOCK) begin
    lf <= lfsr(lf);
    rnd <= lf[5:0];
  end
  spi_status_flags u_dut (.CLOCK, .RESETN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .ENABLE, .DEEP_BUF, .FRAMED, .BUSY, .SHIFT_EMPTY,
    .RX_WORD_DONE, .RX_READ, .TX_WRITE, .TX_LOAD, .FRAME_ERR, .TX_UNDERRUN, .RX_ACCEPT,
    .RX_DISCARD, .IRQ);
  engine_model u_eng (.clk(CLOCK), .rst_n(RESETN), .run, .drain, .rnd,
    .rx_done(RX_WORD_DONE), .rx_read(RX_READ), .tx_write(TX_WRITE), .tx_load(TX_LOAD));
  // predicts occupancy, overflow and per-word outcome from the engine pulses
  always @(posedge CLOCK) begin
    if (RESETN) begin
      `CHK(RX_DISCARD, dq)
      `CHK(RX_ACCEPT, aq)
      dq = 0;
      aq = 0;
      if (!ENABLE) begin
        rxc = 0;
        txc = 0;
      end else begin
        if (RX_WORD_DONE && rxc >= full_at()) begin
          dq = 1;
          ov = 1;
          ev[2] = 1;
        end else if (RX_WORD_DONE) begin
          aq = 1;
          rxc++;
          ev[3] = 1;
        end
        if (RX_READ && rxc != 5'h00) rxc--;
        if (TX_WRITE && txc < full_at()) txc++;
        if (TX_LOAD && txc != 5'h00) txc--;
      end
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input word_t d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    r = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input word_t e);
    apb(1'b0, a, 32'h0);
    `CHK(r, e)
  endtask
  task automatic hit();
    @(posedge CLOCK);
    FRAME_ERR <= 1'b1;
    TX_UNDERRUN <= 1'b1;
    @(posedge CLOCK);
    FRAME_ERR <= 1'b0;
    TX_UNDERRUN <= 1'b0;
  endtask
  task automatic traffic(input logic dr, input int n);
    drain <= dr;
    run <= 1'b1;
    repeat (n) @(posedge CLOCK);
    run <= 1'b0;
    repeat (4) @(posedge CLOCK);
  endtask
  task automatic end_sim();
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    RESETN <= 1'b1;
    rd(8'h00, 32'h0000_00A8);
    rd(8'h04, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_00A8);
    `CHK(er, 1'b0)
    rd(8'h0C, 32'h0000_0000);
    `CHK(er, 1'b1)
    apb(1'b1, 8'h08, 32'h0000_000F);
    rd(8'h08, 32'h0000_000F);
    ENABLE <= 1'b1;
    DEEP_BUF <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      FRAMED <= f[0];
      hit();
      fe = f[0];
      tur = f[0];
      rd(8'h00, exp_stat());
    end
    ev = 4'h3;
    rd(8'h04, {28'h0, ev});
    `CHK(IRQ, 1'b1)
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    BUSY <= 1'b1;
    SHIFT_EMPTY <= 1'b0;
    @(posedge CLOCK);
    rd(8'h00, exp_stat());
    traffic(1'b0, 600);
    rd(8'h00, exp_stat());
    rd(8'h04, {28'h0, ev});
    `CHK(IRQ, 1'b1)
    apb(1'b1, 8'h04, 32'h0000_000F);
    ev = 4'h0;
    traffic(1'b1, 600);
    rd(8'h00, exp_stat());
    `CHK(IRQ, 1'b0)
    apb(1'b1, 8'h00, 32'h0000_0000);
    fe = 0;
    tur = 0;
    ov = 0;
    rd(8'h00, exp_stat());
    // clock enable low: flag pulses must leave no trace
    CE <= 1'b0;
    hit();
    CE <= 1'b1;
    @(posedge CLOCK);
    rd(8'h00, exp_stat());
    // single-word buffer mode
    DEEP_BUF <= 1'b0;
    traffic(1'b0, 100);
    rd(8'h00, exp_stat());
    DEEP_BUF <= 1'b1;
    traffic(1'b0, 300);
    hit();
    fe = 1;
    tur = 1;
    rd(8'h00, exp_stat());
    apb(1'b1, 8'h08, 32'h0000_0000);
    repeat (2) @(posedge CLOCK);
    `CHK(IRQ, 1'b0)
    ENABLE <= 1'b0;
    repeat (2) @(posedge CLOCK);
    ENABLE <= 1'b1;
    ov = 0;
    tur = 0;
    @(posedge CLOCK);
    rd(8'h00, exp_stat());
    end_sim();
  end
endmodule
`default_nettype wire
